// >>> src/dpm_probe_mux.v
// Diagnostic probe pin multiplexer: four multifunction pins and the global clock pin.
// Assumes the mode pin and all pins arrive asynchronously to CORE_CLK; pins are
// resolved outside from their out and oe signals.
`timescale 1ns/1ps
// The shared constants are needed before the parameter defaults below.
`include "dpm_consts.vh"
module dpm_probe_mux #(
  parameter SEL_W = `DPM_SEL_W,
  parameter NODES = `DPM_NODES
) (
  input wire CORE_CLK,
  input wire RST,
  input wire MODE_SELECT,
  input wire [NODES-1:0] PROBE_NODES,
  input wire GCLK_AS_IO,
  input wire GCLK_PIN_IN,
  output reg GCLK_BUF,
  output wire GCLK_PIN_OUT,
  output wire GCLK_PIN_OE,
  output wire GCLK_CORE_IN,
  input wire [1:0] GCLK_IO_MODE,
  input wire GCLK_CORE_OUT,
  input wire GCLK_CORE_OE,
  input wire [7:0] USER_IO_MODE,
  input wire [3:0] USER_CORE_OUT,
  input wire [3:0] USER_CORE_OE,
  output reg [3:0] USER_CORE_IN,
  input wire [3:0] PIN_IN,
  output reg [3:0] PIN_OUT,
  output reg [3:0] PIN_OE,
  output reg PROBE_LOCKED,
  output reg [SEL_W-1:0] SEL_A,
  output reg [SEL_W-1:0] SEL_B
);
  // Pin index: 0 diag_clock_in, 1 diag_serial_in, 2 probe_out_a, 3 probe_out_b.
  // Two operating states: plain user I/O, or the diagnostic roles on the four pins.
  localparam ST_IO = 1'b0;
  localparam ST_DIAG = 1'b1;

  // Synchroniser stages for the mode pin and the two diagnostic pins.
  reg mode_meta;
  reg mode_sync;
  reg [1:0] diag_clock_in_meta;
  reg [1:0] diag_clock_in_sync;
  reg diag_clock_in_prev;
  // Selector shift frame, its bit counter and the operating state.
  reg [`DPM_FRAME_W-1:0] shift;
  reg [3:0] bit_cnt;
  reg state;
  reg next_state;
  // Two stages for the probed nodes, which come from logic on other clocks.
  reg [NODES-1:0] node_meta;
  reg [NODES-1:0] node_sync;
  // First stage for the global clock pin.
  reg gclk_meta;
  // Rise strobe of the diagnostic clock and the outputs of the four user buffers.
  wire diag_clock_in_rise;
  wire [3:0] buf_out;
  wire [3:0] buf_oe;
  wire [3:0] buf_in;

  // Picks one node out of the probe bus.
  // Both probes share it, so the two outputs decode a selector the same way.
  function node_pick;
    input [NODES-1:0] nodes;
    input [SEL_W-1:0] sel;
    begin
      node_pick = nodes[sel];
    end
  endfunction

  // Mode pin, diagnostic clock, serial input and probed nodes pass two flip-flops each.
  // The serial bit travels beside the clock through the same stages; the station holds
  // it steady for many core cycles around each rise, so the pair arrives consistent.
  // Each node is probed as a single bit, so no node word has to arrive coherent.
  always @(posedge CORE_CLK) begin
    if (RST) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      diag_clock_in_meta <= 2'b00;
      diag_clock_in_sync <= 2'b00;
      diag_clock_in_prev <= 1'b0;
      node_meta <= {NODES{1'b0}};
      node_sync <= {NODES{1'b0}};
    end else begin
      mode_meta <= MODE_SELECT;
      mode_sync <= mode_meta;
      diag_clock_in_meta <= PIN_IN[1:0];
      diag_clock_in_sync <= diag_clock_in_meta;
      diag_clock_in_prev <= diag_clock_in_sync[0];
      node_meta <= PROBE_NODES;
      node_sync <= node_meta;
    end
  end

  // A rise is the synchronised level high after a low one. Both stages reset low,
  // the idle level of the clock pin, so no false rise follows reset.
  assign diag_clock_in_rise = diag_clock_in_sync[0] & ~diag_clock_in_prev;

  // Mode state follows the synchronised mode pin.
  // One more stage gives every process below the same settled view of the mode,
  // so pins and shifting switch roles on the same edge.
  always @* begin
    next_state = mode_sync ? ST_DIAG : ST_IO;
  end

  // Selector shifting and permanent lock. The frame comes in lowest bit first; at the
  // last rise the first twelve bits sit in shift[12:1] and the lock bit is the live one.
  // The lock can only be set, so a later frame can move the selectors but never
  // bring a node back onto a probe pin. Dropping mode-select restarts the bit count,
  // so a cut frame never mixes with the next one.
  always @(posedge CORE_CLK) begin
    if (RST) begin
      state <= ST_IO;
      shift <= {`DPM_FRAME_W{1'b0}};
      bit_cnt <= 4'h0;
      SEL_A <= `DPM_SEL_RST;
      SEL_B <= `DPM_SEL_RST;
      PROBE_LOCKED <= 1'b0;
    end else begin
      state <= next_state;
      case (state)
        ST_DIAG: begin
          if (diag_clock_in_rise) begin
            shift <= {diag_clock_in_sync[1], shift[`DPM_FRAME_W-1:1]};
            if (bit_cnt == `DPM_FRAME_W - 1) begin
              bit_cnt <= 4'h0;
              SEL_A <= shift[`DPM_SEL_A_LSB+SEL_W:`DPM_SEL_A_LSB+1];
              SEL_B <= shift[`DPM_SEL_B_LSB+SEL_W:`DPM_SEL_B_LSB+1];
              if (diag_clock_in_sync[1])
                PROBE_LOCKED <= 1'b1;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_IO: begin
          bit_cnt <= 4'h0; // Leaving diagnostic mode aborts a partial frame.
        end
        default: bit_cnt <= 4'h0;
      endcase
    end
  end

  // One user buffer per multifunction pin. They run all the time, so a pin handed
  // back to the user when mode-select falls already carries a settled level
  // and drive.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pin_buf
      dpm_io_buffer u_buf (
        .clk(CORE_CLK),
        .rst(RST),
        .mode(USER_IO_MODE[2*g+1:2*g]),
        .core_out(USER_CORE_OUT[g]),
        .core_oe(USER_CORE_OE[g]),
        .pin_in(PIN_IN[g]),
        .pin_out(buf_out[g]),
        .pin_oe(buf_oe[g]),
        .core_in(buf_in[g])
      );
    end
  endgenerate

  // Pins take the special role in diagnostic mode, else the user buffers.
  // In diagnostic mode the clock and serial pins are released for the station,
  // and the probe pins drive always, low once the lock is set.
  always @(posedge CORE_CLK) begin
    if (RST) begin
      PIN_OUT <= 4'h0;
      PIN_OE <= 4'h0;
      USER_CORE_IN <= 4'h0;
    end else if (state == ST_DIAG) begin
      PIN_OUT[1:0] <= 2'b00;
      PIN_OE[1:0] <= 2'b00;
      PIN_OUT[2] <= ~PROBE_LOCKED & node_pick(node_sync, SEL_A);
      PIN_OUT[3] <= ~PROBE_LOCKED & node_pick(node_sync, SEL_B);
      PIN_OE[3:2] <= 2'b11;
      USER_CORE_IN <= 4'h0;
    end else begin
      PIN_OUT <= buf_out;
      PIN_OE <= buf_oe;
      USER_CORE_IN <= buf_in;
    end
  end

  // The global clock pin has its own buffer; as a plain clock input it never
  // drives, so a clock source on the pin cannot be fought. Its drive enable is
  // only honoured while the pin is configured as a user I/O.
  dpm_io_buffer u_gclk (
    .clk(CORE_CLK),
    .rst(RST),
    .mode(GCLK_AS_IO ? GCLK_IO_MODE : `DPM_IO_INPUT),
    .core_out(GCLK_CORE_OUT),
    .core_oe(GCLK_CORE_OE & GCLK_AS_IO),
    .pin_in(GCLK_PIN_IN),
    .pin_out(GCLK_PIN_OUT),
    .pin_oe(GCLK_PIN_OE),
    .core_in(GCLK_CORE_IN)
  );

  // Buffered global clock toward the logic; held low when the pin is a user I/O.
  // The pin is an outside level, so it passes two stages before the logic sees it;
  // the second stage is the buffered clock itself.
  always @(posedge CORE_CLK) begin
    if (RST) begin
      gclk_meta <= 1'b0;
      GCLK_BUF <= 1'b0;
    end else begin
      gclk_meta <= GCLK_PIN_IN;
      GCLK_BUF <= gclk_meta & ~GCLK_AS_IO;
    end
  end
endmodule

// >>> src/dpm_consts.vh
// Constants for the diagnostic probe pin multiplexer.
// Assumes inclusion by bare name from the design files under src/.
`ifndef DPM_CONSTS_VH
`define DPM_CONSTS_VH
// Width of one probe node selector, in bits.
`define DPM_SEL_W 6
// Number of internal nodes that can be probed.
`define DPM_NODES 64
// Length of the selector shift frame: two selectors plus a lock bit.
`define DPM_FRAME_W 13
// Bit position of the permanent probe-lock bit in the shift frame.
`define DPM_LOCK_BIT 12
// Field positions of the two selectors in the shift frame.
`define DPM_SEL_A_LSB 0
`define DPM_SEL_B_LSB 6
// Reset value of the selectors.
`define DPM_SEL_RST 6'h00
// I/O buffer configuration codes.
`define DPM_IO_INPUT 2'h0
`define DPM_IO_OUTPUT 2'h1
`define DPM_IO_TRISTATE 2'h2
`define DPM_IO_BIDIR 2'h3
`endif

// >>> src/dpm_io_buffer.v
// One configurable user I/O buffer: input, output, three-state or bidirectional.
// Assumes the pin level is resolved outside from out and oe.
`timescale 1ns/1ps
module dpm_io_buffer (
  input wire clk,
  input wire rst,
  input wire [1:0] mode,
  input wire core_out,
  input wire core_oe,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output reg core_in
);
  reg pin_meta;
  reg pin_sync;

`include "dpm_consts.vh"

  // Two flip-flops bring the pin level into the core clock domain.
  always @(posedge clk) begin
    if (rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Enable and core input follow the configured buffer type; the drive level is always core_out.
  always @(posedge clk) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      core_in <= 1'b0;
    end else begin
      pin_out <= core_out;
      core_in <= (mode == `DPM_IO_OUTPUT) ? 1'b0 : pin_sync;
      case (mode)
        `DPM_IO_INPUT: pin_oe <= 1'b0;
        `DPM_IO_OUTPUT: pin_oe <= 1'b1;
        `DPM_IO_TRISTATE: pin_oe <= core_oe;
        `DPM_IO_BIDIR: pin_oe <= core_oe;
        default: pin_oe <= 1'b0;
      endcase
    end
  end
endmodule

// >>> tb/dpm_probe_props.sv
// Port checker for the probe pin multiplexer.
// Assumes it is bound to dpm_probe_mux and sees only its ports.
`timescale 1ns/1ps
module dpm_probe_props #(
  parameter SEL_W = 6,
  parameter NODES = 64
) (
  input wire CORE_CLK,
  input wire RST,
  input wire MODE_SELECT,
  input wire [NODES-1:0] PROBE_NODES,
  input wire GCLK_AS_IO,
  input wire GCLK_PIN_IN,
  input wire GCLK_BUF,
  input wire [7:0] USER_IO_MODE,
  input wire [3:0] USER_CORE_IN,
  input wire [3:0] PIN_IN,
  input wire [3:0] PIN_OUT,
  input wire [3:0] PIN_OE,
  input wire PROBE_LOCKED,
  input wire [SEL_W-1:0] SEL_A,
  input wire [SEL_W-1:0] SEL_B
);
  // All checks run on the core clock and rest while reset is applied.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_diag_drive: assert property (MODE_SELECT [*5] |-> PIN_OE == 4'hc)
    else $error("diagnostic pin enables wrong");
  chk_diag_core_in: assert property (MODE_SELECT [*5] |-> USER_CORE_IN == 4'h0)
    else $error("core input not quiet in diagnostic mode");
  chk_input_quiet: assert property ((!MODE_SELECT && USER_IO_MODE[1:0] == 2'h0) [*3]
    |-> !PIN_OE[0]) else $error("input buffer drives its pin");
  chk_sel_refused: assert property (!MODE_SELECT [*4]
    |-> $stable(SEL_A) && $stable(SEL_B)) else $error("selector moved in I/O mode");
  chk_sel_on_clock: assert property ($changed(SEL_A) || $changed(SEL_B)
    |-> $past(MODE_SELECT, 2) && $past(PIN_IN[0], 2)) else $error("selector moved off clock");
  chk_probe_live: assert property ((MODE_SELECT && !PROBE_LOCKED && $stable(PROBE_NODES)
    && $stable(SEL_A) && $stable(SEL_B)) [*6]
    |-> PIN_OUT[3:2] == {PROBE_NODES[SEL_B], PROBE_NODES[SEL_A]})
    else $error("probe value wrong");
  chk_lock_sticky: assert property (PROBE_LOCKED |=> PROBE_LOCKED)
    else $error("probe lock released");
  chk_lock_dark: assert property ((MODE_SELECT && PROBE_LOCKED) [*5]
    |-> PIN_OUT[3:2] == 2'h0) else $error("locked probe shows a node");
  chk_gclk_buf: assert property ((!GCLK_AS_IO && GCLK_PIN_IN) [*5] |-> GCLK_BUF)
    else $error("clock buffer does not follow pin");
  chk_gclk_io: assert property (GCLK_AS_IO [*3] |-> !GCLK_BUF)
    else $error("clock buffer active in I/O use");
  // Main scenarios reached.
  cov_frame: cover property (MODE_SELECT && $changed(SEL_A));
  cov_lock: cover property ($rose(PROBE_LOCKED));
  cov_gclk: cover property ($rose(GCLK_BUF));
endmodule
bind dpm_probe_mux dpm_probe_props #(.SEL_W(SEL_W), .NODES(NODES)) i_props (
  .CORE_CLK(CORE_CLK), .RST(RST), .MODE_SELECT(MODE_SELECT), .PROBE_NODES(PROBE_NODES),
  .GCLK_AS_IO(GCLK_AS_IO), .GCLK_PIN_IN(GCLK_PIN_IN), .GCLK_BUF(GCLK_BUF),
  .USER_IO_MODE(USER_IO_MODE), .USER_CORE_IN(USER_CORE_IN), .PIN_IN(PIN_IN),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PROBE_LOCKED(PROBE_LOCKED), .SEL_A(SEL_A), .SEL_B(SEL_B));

// >>> tb/dpm_station.sv
// Model of the diagnostic station driving the clock and serial pins.
// Assumes its clock runs at 160 ns and stands low between frames.
`timescale 1ns/1ps
module dpm_station (
  output reg diag_clock_in,
  output reg diag_serial_in
);
  integer i;
  // Both lines idle low before the first frame.
  initial begin
    diag_clock_in = 1'b0;
    diag_serial_in = 1'b0;
  end
  // Shifts one frame, lowest bit first, data settled well around each rise.
  task send(input [12:0] frame);
    for (i = 0; i < 13; i = i + 1) begin
      diag_serial_in = frame[i];
      #40 diag_clock_in = 1'b1;
      #80 diag_clock_in = 1'b0;
      #40;
    end
    diag_serial_in = ~diag_serial_in; // The released line no longer shows the last bit.
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the probe pin multiplexer.
// Assumes the station model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0, rst = 1'b1, mode = 1'b0, as_io = 1'b0, gpin = 1'b0, gout = 1'b0;
  reg [1:0] gmode = 2'h0, drv = 2'h2;
  reg [7:0] umode = 8'h00;
  reg [3:0] uout = 4'h6, uoe = 4'h5;
  reg goe = 1'b1;
  reg [63:0] nodes = 64'h0000_0000_0000_0000;
  wire diag_clock_in, diag_serial_in, gbuf, gpo, gpoe, gcin, locked;
  wire [3:0] pin_in, pin_out, pin_oe, ucin;
  wire [5:0] sel_a, sel_b;
  integer err_count = 0, check_count = 0, k;
  // Pin levels resolve from the device drive and the outside parties.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {drv, diag_serial_in, diag_clock_in});
  dpm_station i_st (.diag_clock_in(diag_clock_in), .diag_serial_in(diag_serial_in));
  dpm_probe_mux i_dut (.CORE_CLK(clk), .RST(rst), .MODE_SELECT(mode), .PROBE_NODES(nodes),
    .GCLK_AS_IO(as_io), .GCLK_PIN_IN(gpin), .GCLK_BUF(gbuf), .GCLK_PIN_OUT(gpo),
    .GCLK_PIN_OE(gpoe), .GCLK_CORE_IN(gcin), .GCLK_IO_MODE(gmode), .GCLK_CORE_OUT(gout),
    .GCLK_CORE_OE(goe), .USER_IO_MODE(umode), .USER_CORE_OUT(uout), .USER_CORE_OE(uoe),
    .USER_CORE_IN(ucin), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PROBE_LOCKED(locked), .SEL_A(sel_a), .SEL_B(sel_b));
  // Core clock of 4 ns.
  initial begin
    forever #2 clk = ~clk;
  end
  task w(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Every buffer code in I/O mode; a frame sent meanwhile, with the diagnostic pins
  // as plain inputs so that it reaches them, is ignored.
  task t_io;
    for (k = 0; k < 4; k = k + 1) begin
      umode = {4{k[1:0]}};
      w(8);
      chk(pin_oe, k == 0 ? 4'h0 : k == 1 ? 4'hf : 4'h5);
      chk(ucin, k == 0 ? 4'h8 : k == 1 ? 4'h0 : 4'hc);
      if (k != 0) chk(pin_out, uout);
    end
    umode = 8'h00;
    w(8);
    i_st.send(13'h1_fff);
    w(4);
    chk({locked, sel_b, sel_a}, 13'h0000);
    $display("test io done");
  endtask
  // Global clock pin as buffered clock, then as a user output and a three-state pin.
  task t_gclk;
    gpin = 1'b1;
    w(6);
    chk(gbuf, 1'b1);
    as_io = 1'b1;
    gmode = 2'h1;
    gout = 1'b1;
    w(6);
    chk({gbuf, gpoe, gpo, gcin}, 4'h6);
    gmode = 2'h2;
    goe = 1'b0;
    w(6);
    chk({gpoe, gcin}, 2'h1);
    $display("test gclk done");
  endtask
  // Selectors shifted in, then both probes follow their nodes.
  task t_probe;
    mode = 1'b1;
    w(6);
    i_st.send({1'b0, 6'h01, 6'h3f});
    w(4);
    chk({sel_b, sel_a}, 12'h07f);
    chk({pin_oe, ucin}, 8'hc0);
    nodes = 64'h8000_0000_0000_0000;
    w(6);
    chk(pin_out[3:2], 2'h1);
    nodes = 64'h0000_0000_0000_0002;
    w(6);
    chk(pin_out[3:2], 2'h2);
    $display("test probe done");
  endtask
  // Lock frame darkens both probes and survives later frames and mode changes.
  task t_lock;
    i_st.send({1'b1, 6'h00, 6'h00});
    nodes = 64'hffff_ffff_ffff_ffff;
    w(6);
    chk({locked, pin_out[3:2]}, 3'h4);
    i_st.send({1'b0, 6'h02, 6'h03});
    w(4);
    chk({sel_b, sel_a}, 12'h083);
    mode = 1'b0;
    w(6);
    mode = 1'b1;
    w(8);
    chk({locked, pin_out[3:2]}, 3'h4);
    $display("test lock done");
  endtask
  // Reset for 12 cycles, then the scenarios in turn.
  initial begin
    w(12);
    rst = 1'b0;
    w(4);
    t_io;
    t_gclk;
    t_probe;
    t_lock;
    finish_test;
  end
  // Cuts a hang short well beyond the expected run.
  initial begin
    #100000;
    err_count = err_count + 1;
    finish_test;
  end
endmodule
